// ---- design/azg_ctrl.sv ----
// Offset-chop sequencer and gain split for a delta-sigma converter.
// Assumes a filter that runs one conversion per start and returns a result.
`timescale 1ns/100ps
// Function
// - Chop enable bit, reset value 0 disables, 1 enables.
// - With chop, two conversions per result: normal then swapped inputs.
// - Result is normal minus swapped, halved.
// - Single-shot with chop takes twice the plain conversion period.
// - Continuous with chop resets the filter between conversions.
// - Continuous with chop becomes gapless back-to-back single shots.
// - Three-bit gain code selects 0.333 up to 64 total.
// - Codes up to 101 analog only; 110, 111 analog 16 with digital 2, 4.
// - Digital gain is left shift and saturate, not multiply.
// - Digital gain sits in the filter path before the result register.
// - Results are 16 bits wide.
module azg_ctrl #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic offset_chop_enable,
    input wire logic [1:0] conversion_kind_select,
    input wire logic [2:0] gain_code,
    input wire logic start,
    input wire logic filt_done,
    input wire logic [W-1:0] filt_data,
    output logic filt_start,
    output logic filt_reset,
    output logic mux_swap,
    output logic [2:0] analog_gain_sel,
    output logic [W-1:0] result_register,
    output logic result_valid
);
    import azg_pkg::*;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Halving and saturation are sized for the package result width
    if (W != RES_W) begin
        $error("Result width must match the package result width");
    end

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Codes above the analog range need the digital stage
    function automatic logic needs_digital(input logic [2:0] code);
        return code > GAIN_ANA_MAX;
    endfunction

    // Analog stage tops out at 16x
    function automatic logic [2:0] analog_of(input logic [2:0] code);
        logic [2:0] ana;
        ana = code;
        if (needs_digital(code)) begin
            ana = ANA_16X;
        end
        return ana;
    endfunction

    // Left-shift count of the digital stage
    function automatic logic [1:0] shift_of(input logic [2:0] code);
        logic [1:0] sh;
        case (code)
            GAIN_X2: sh = SHIFT_X2;
            GAIN_X4: sh = SHIFT_X4;
            default: sh = SHIFT_X1;
        endcase
        return sh;
    endfunction

    // States in which the filter runs one chop conversion
    function automatic logic is_chop_conv(input azg_state_e s);
        return (s == AZG_NORM) || (s == AZG_SWAP);
    endfunction

    // ----------------------------------------
    // Gain split
    // ----------------------------------------
    wire logic [2:0] ana_nxt = analog_of(gain_code);
    wire logic [1:0] shift_nxt = shift_of(gain_code);
    wire logic [W-1:0] gained;

    // Registered so the analog stage never sees a decode glitch
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_gain_sel <= ANA_16X;
        end else begin
            analog_gain_sel <= ana_nxt;
        end
    end

    // Shift in filter path, before the result register
    azg_dgain #(.W(W)) u_dgain (
        .din(filt_data),
        .shift(shift_nxt),
        .dout(gained)
    );

    // ----------------------------------------
    // Start qualification
    // ----------------------------------------
    azg_state_e state_r, state_nxt;
    logic cont_r;
    wire logic seq_idle = state_r == AZG_IDLE;
    wire logic cont_mode = conversion_kind_select == MODE_CONT;
    // A chop start inside a chop sequence is refused
    wire logic chop_take = start && offset_chop_enable && seq_idle;
    wire logic plain_take = start && !offset_chop_enable;
    wire logic norm_done = (state_r == AZG_NORM) && filt_done;
    wire logic chop_done = (state_r == AZG_SWAP) && filt_done;
    wire logic plain_done = seq_idle && filt_done;
    wire logic restart = cont_r && offset_chop_enable;

    // Mode latched at an accepted start only
    always_ff @(posedge clk) begin
        if (rst) begin
            cont_r <= 1'b0;
        end else if (start && seq_idle) begin
            cont_r <= cont_mode;
        end
    end

    // ----------------------------------------
    // Chop sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            AZG_IDLE: begin
                if (chop_take) begin
                    state_nxt = AZG_NORM;
                end
            end
            AZG_NORM: begin
                if (filt_done) begin
                    state_nxt = AZG_SWAP;
                end
            end
            // Second conversion doubles the period
            AZG_SWAP: begin
                if (filt_done) begin
                    state_nxt = AZG_DONE;
                end
            end
            // Gapless restart in continuous mode
            AZG_DONE: begin
                if (restart) begin
                    state_nxt = AZG_NORM;
                end else begin
                    state_nxt = AZG_IDLE;
                end
            end
            default: begin
                state_nxt = AZG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= AZG_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Filter and multiplexer control
    // ----------------------------------------
    wire logic conv_entry = is_chop_conv(state_nxt) && (state_nxt != state_r);
    wire logic start_nxt = conv_entry || plain_take;
    // Each chop conversion starts from a cleared filter
    wire logic reset_nxt = conv_entry;
    wire logic swap_nxt = state_nxt == AZG_SWAP;

    always_ff @(posedge clk) begin
        if (rst) begin
            filt_start <= 1'b0;
        end else begin
            filt_start <= start_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            filt_reset <= 1'b0;
        end else begin
            filt_reset <= reset_nxt;
        end
    end

    // Inputs stay swapped for the whole second conversion
    always_ff @(posedge clk) begin
        if (rst) begin
            mux_swap <= 1'b0;
        end else begin
            mux_swap <= swap_nxt;
        end
    end

    // ----------------------------------------
    // Chop arithmetic
    // ----------------------------------------
    logic [W-1:0] norm_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            norm_r <= '0;
        end else if (norm_done) begin
            norm_r <= gained;
        end
    end

    // One bit wider so the difference cannot wrap
    wire logic signed [W:0] diff = $signed({norm_r[W-1], norm_r}) -
                                   $signed({gained[W-1], gained});
    // Arithmetic shift floors toward minus infinity for both signs
    wire logic signed [W:0] half_wide = diff >>> 1;
    wire logic [W-1:0] half = half_wide[W-1:0];

    // ----------------------------------------
    // Result register
    // ----------------------------------------
    wire logic res_load = chop_done || plain_done;
    wire logic [W-1:0] res_nxt = chop_done ? half : gained;

    always_ff @(posedge clk) begin
        if (rst) begin
            result_register <= '0;
        end else if (res_load) begin
            result_register <= res_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= res_load;
        end
    end
endmodule

// ---- design/azg_dgain.sv ----
// Digital gain stage: left shift with saturation to the result width.
// Assumes the input is a signed result from the decimation path.
`timescale 1ns/100ps
module azg_dgain #(
    parameter int W = 16
) (
    input wire logic [W-1:0] din,
    input wire logic [1:0] shift,
    output logic [W-1:0] dout
);
    import azg_pkg::*;
    // Sign bit plus at least one magnitude bit
    if (W < 2) begin
        $error("Gain stage width too small");
    end
    wire logic signed [W+1:0] ext = {{2{din[W-1]}}, din};
    wire logic signed [W+1:0] shv = ext <<< shift;
    wire logic signed [W+1:0] maxv = {3'h0, {(W-1){1'b1}}};
    wire logic signed [W+1:0] minv = ~maxv;
    // Saturate instead of wrapping
    assign dout = (shv > maxv) ? maxv[W-1:0] : (shv < minv) ? minv[W-1:0] : shv[W-1:0];
endmodule

// ---- inc/azg_pkg.sv ----
// Constants shared by the offset-chop and gain control block.
// Assumes a single clock domain and a filter that reports raw results.
package azg_pkg;
    localparam int RES_W = 16;
    localparam logic [1:0] MODE_CONT = 2'h3;
    localparam logic [2:0] GAIN_ANA_MAX = 3'h5;
    localparam logic [2:0] GAIN_X2 = 3'h6;
    localparam logic [2:0] GAIN_X4 = 3'h7;
    localparam logic [1:0] SHIFT_X1 = 2'h0;
    localparam logic [1:0] SHIFT_X2 = 2'h1;
    localparam logic [1:0] SHIFT_X4 = 2'h2;
    localparam logic [2:0] ANA_16X = 3'h5;
    typedef enum logic [2:0] {
        AZG_IDLE = 3'h0,
        AZG_NORM = 3'h1,
        AZG_SWAP = 3'h2,
        AZG_DONE = 3'h3
    } azg_state_e;
endpackage

// ---- tb/azg_ctrl_assertions.sv ----
// Port-level assertions for the offset-chop and gain controller.
// Assumes a bind onto azg_ctrl made from the bench top file.
`timescale 1ns/100ps
module azg_ctrl_assertions import azg_pkg::*; #(parameter int W = 16) (
    input wire logic clk,
    input wire logic rst,
    input wire logic offset_chop_enable,
    input wire logic start,
    input wire logic filt_done,
    input wire logic filt_start,
    input wire logic filt_reset,
    input wire logic mux_swap,
    input wire logic result_valid,
    input wire logic [1:0] conversion_kind_select,
    input wire logic [2:0] gain_code,
    input wire logic [2:0] analog_gain_sel,
    input wire logic [W-1:0] filt_data,
    input wire logic [W-1:0] result_register
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_ANA_GAIN: assert property (!$past(rst) && $stable(gain_code) |->
        analog_gain_sel == (gain_code > GAIN_ANA_MAX ? ANA_16X : gain_code)) else $error("gain");
    AST_PLAIN_START: assert property (start && !offset_chop_enable |=> filt_start)
        else $error("no start");
    AST_CHOP_RESET: assert property (filt_start && offset_chop_enable |-> filt_reset)
        else $error("no filter reset");
    AST_SWAP_NEXT: assert property (filt_done && offset_chop_enable && !mux_swap
        |=> filt_start && mux_swap) else $error("no swap");
    AST_SWAP_HOLD: assert property (mux_swap && !filt_done |=> mux_swap)
        else $error("swap dropped");
    AST_RESULT: assert property (filt_done && mux_swap |=> result_valid)
        else $error("no result");
    AST_AFTER_SWAP: assert property (result_valid && offset_chop_enable |->
        $past(mux_swap)) else $error("early result");
    AST_PULSE: assert property (result_valid |=> !result_valid)
        else $error("valid not a pulse");
    AST_HOLD_RES: assert property (!result_valid |-> $stable(result_register))
        else $error("result moved");
    AST_CONT: assert property (result_valid && offset_chop_enable &&
        conversion_kind_select == MODE_CONT |-> ##[0:1] filt_start) else $error("gap");
    AST_UNITY_GAIN: assert property (filt_done && !offset_chop_enable &&
        !mux_swap && gain_code <= GAIN_ANA_MAX |=> result_register == $past(filt_data))
        else $error("unity gain result wrong");
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the offset-chop and gain controller.
// Assumes the package and design are compiled first; plays the filter itself.
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("Error %s exp %h got %h", n, e, a); end end
module tb_top;
    import azg_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b0, st = 1'b0, fd = 1'b0, fs, fr, ms, rv;
    logic [1:0] cm = '0;
    logic [2:0] gc = '0, ag;
    logic [15:0] fdat = '0, lf = 16'hc93d, rr;
    int err_count = 0, cmp_count = 0;
    azg_ctrl #(.W(RES_W)) DUT (.clk(clk), .rst(rst), .offset_chop_enable(ce), .start(st),
        .conversion_kind_select(cm), .gain_code(gc), .filt_done(fd), .filt_data(fdat),
        .filt_start(fs), .filt_reset(fr), .mux_swap(ms), .analog_gain_sel(ag),
        .result_register(rr), .result_valid(rv));
    initial forever #25 clk = ~clk;
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    // Saturate, since wrapping would flip the sign at high gain
    function automatic logic signed [15:0] dg(logic signed [15:0] d, logic [2:0] g);
        logic signed [17:0] v;
        v = 18'(d) <<< ((g == GAIN_X4) ? 2 : (g == GAIN_X2));
        return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : v[15:0];
    endfunction
    task tick;
        @(posedge clk);
        #1;
    endtask
    task give_verdict;
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic conv(input logic c, input logic [1:0] m, input logic [2:0] g,
        input logic [15:0] a, b);
        logic signed [16:0] df;
        int n;
        // Idle cycle first: a chop start in the closing cycle of a sequence is refused
        tick;
        ce = c;
        cm = m;
        gc = g;
        st = 1'b1;
        tick;
        st = 1'b0;
        for (int k = 0; k <= c; k++) begin
            n = 0;
            while (!fs && n < 20) begin
                tick;
                n++;
            end
            `CHK("start", 1'b1, fs)
            `CHK("swap", 1'(k), ms)
            `CHK("filter reset", c, fr)
            tick;
            tick;
            fd = 1'b1;
            fdat = k ? b : a;
            tick;
            fd = 1'b0;
        end
        n = 0;
        while (!rv && n < 5) begin
            tick;
            n++;
        end
        df = c ? (17'(dg(a, g)) - 17'(dg(b, g))) >>> 1 : 17'(dg(a, g));
        `CHK("valid", 1'b1, rv)
        `CHK("result", df[15:0], rr)
        `CHK("again", (g > GAIN_ANA_MAX) ? ANA_16X : g, ag)
        if (c && m == MODE_CONT) begin
            tick;
            `CHK("restart", 1'b1, fs)
            `CHK("restart reset", 1'b1, fr)
        end
    endtask
    initial begin
        repeat (20) tick;
        rst = 1'b0;
        for (int i = 0; i < 48; i++) begin
            conv(i[0], 2'h0, 3'(i / 2), i < 16 ? 16'h7fff : rnd(), i < 16 ? 16'h8000 : rnd());
        end
        conv(1'b1, MODE_CONT, GAIN_X4, rnd(), rnd());
        // Reset in mid-sequence must abort the running chop conversion
        rst = 1'b1;
        repeat (2) tick;
        `CHK("reset valid", 1'b0, rv)
        `CHK("reset start", 1'b0, fs)
        `CHK("reset filter reset", 1'b0, fr)
        `CHK("reset swap", 1'b0, ms)
        `CHK("reset gain", ANA_16X, ag)
        `CHK("reset result", 16'h0000, rr)
        rst = 1'b0;
        conv(1'b1, 2'h0, GAIN_X2, rnd(), rnd());
        repeat (4) tick;
        give_verdict;
    end
    initial begin
        #200000;
        err_count++;
        give_verdict;
    end
endmodule
bind azg_ctrl azg_ctrl_assertions #(.W(W)) u_chk (.clk(clk), .rst(rst), .start(start),
    .offset_chop_enable(offset_chop_enable), .filt_done(filt_done), .filt_start(filt_start),
    .filt_reset(filt_reset), .mux_swap(mux_swap), .result_valid(result_valid),
    .conversion_kind_select(conversion_kind_select), .gain_code(gain_code),
    .analog_gain_sel(analog_gain_sel), .filt_data(filt_data),
    .result_register(result_register));
